// File: encoder_model.sv
`timescale 1ns/100ps
// ==========
// Encoder model: two phases and an index pulse, stepped by the bench.
module encoder_model (
  input wire logic CLK,
  output logic PHASE_A,
  output logic PHASE_B,
  output logic INDEX
);
  logic [1:0] pos;
  // Phase code {A,B} at each position of the up order.
  function automatic logic [1:0] code(input logic [1:0] p);
    logic [1:0] tbl [4];
    tbl = '{2'h0, 2'h2, 2'h3, 2'h1};
    return tbl[p];
  endfunction : code
  // The encoder sits at phase 00 with the index low at start.
  initial begin
    pos = 2'h0;
    PHASE_A = 1'b0;
    PHASE_B = 1'b0;
    INDEX = 1'b0;
  end
  // One step up or down; the index is high only for that step.
  task automatic step(input bit up, input bit idx);
    @(posedge CLK);
    pos = up ? pos + 2'h1 : pos - 2'h1;
    {PHASE_A, PHASE_B} <= code(pos);
    INDEX <= idx;
    @(posedge CLK);
    INDEX <= 1'b0;
  endtask : step
endmodule : encoder_model

// File: qd_pkg.sv
// =====================================================================
// Register map and field layout of the quadrature decoder.
package qd_pkg;
  // Register indices; the APB byte address is four times the index.
  localparam logic [15:0] IDX_CTRL = 16'hA070;
  localparam logic [15:0] IDX_CFG3 = 16'hA072;
  localparam logic [15:0] IDX_FLAGS = 16'hA073;
  localparam logic [15:0] IDX_CNT_LO = 16'hA074;
  localparam logic [15:0] IDX_CNT_HI = 16'hA075;
  localparam logic [15:0] IDX_MAX_LO = 16'hA076;
  localparam logic [15:0] IDX_MAX_HI = 16'hA077;
  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_QUAD = 1;
  localparam int CTRL_RLD_LO = 2;
  localparam int CTRL_DIR = 4;
  // Configuration register 3 fields; bits 7 to 3 are the event enables.
  localparam int CFG3_IDXM_LO = 0;
  localparam int CFG3_IDX_EN = 2;
  localparam int EVT_LO = 3;
  // Event bit numbers, relative to EVT_LO.
  localparam int EV_ERR = 0;
  localparam int EV_CNT = 1;
  localparam int EV_DIR = 2;
  localparam int EV_IDX = 3;
  localparam int EV_TC = 4;
  localparam int NUM_EVT = 5;
  // Reset values.
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] MAX_RESET = 16'h0000;
  // Reload modes.
  localparam logic [1:0] RLD_NONE = 2'h0;
  localparam logic [1:0] RLD_INDEX = 2'h1;
  localparam logic [1:0] RLD_TC = 2'h2;
  localparam logic [1:0] RLD_BOTH = 2'h3;
endpackage : qd_pkg

// File: quadrature_decoder_counter.sv
`timescale 1ns/100ps
// Contract
// - Terminal count at maximum up, zero down
// - Five event interrupt enables in bits 7-3
// - Index input forced low unless enabled
// - Index match applies in double/quadruple modes
// - Match code selects qualifying phase transition
// - Sixteen-bit position count, two bytes, resets zero
// - Count byte reads return live count
// - Count byte writes preset that byte
// - Count preset only while decoder disabled
// - Sixteen-bit maximum count, two bytes, resets zero
// - Maximum reached raises terminal event, reloads
// - Reload mode 00 wraps freely
// - Index reload: zero up, maximum down
// - Mode 11 reloads on first of both
module quadrature_decoder_counter
  import qd_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PHASE_A,
  input wire logic PHASE_B,
  input wire logic INDEX,
  output logic IRQ
);

  // ===================================================================
  // Bus decode
  logic [15:0] reg_idx;
  logic wr_acc;
  logic rd_setup;
  logic [7:0] wdata;
  assign reg_idx = PADDR[17:2];
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign wdata = PWDATA[7:0];
  // Zero wait states; no error response.
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;

  // ===================================================================
  // Configuration registers
  logic [7:0] ctrl_q;
  logic [7:0] cfg3_q;
  logic [15:0] max_q;
  logic [15:0] cnt_q;
  logic [NUM_EVT-1:0] flag_q;
  logic dir_q;
  logic enabled;
  logic quad_mode;
  logic [1:0] reload_mode;
  logic [1:0] index_match_select;
  assign enabled = ctrl_q[CTRL_ENABLE];
  assign quad_mode = ctrl_q[CTRL_QUAD];
  assign reload_mode = ctrl_q[CTRL_RLD_LO +: 2];
  assign index_match_select = cfg3_q[CFG3_IDXM_LO +: 2];

  // Control and event-enable registers take APB writes.
  // event enables
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q <= CFG_RESET;
      cfg3_q <= CFG_RESET;
    end else if (wr_acc) begin
      if (reg_idx == IDX_CTRL) begin
        ctrl_q <= wdata;
      end
      if (reg_idx == IDX_CFG3) begin
        cfg3_q <= wdata;
      end
    end
  end

  // Maximum count bytes are freely writable.
  // maximum count
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      max_q <= MAX_RESET;
    end else if (wr_acc) begin
      if (reg_idx == IDX_MAX_LO) begin
        max_q[7:0] <= wdata;
      end
      if (reg_idx == IDX_MAX_HI) begin
        max_q[15:8] <= wdata;
      end
    end
  end

  // ===================================================================
  // Phase decoding
  logic [1:0] phase_q;
  logic [1:0] phase_now;
  logic moved;
  logic up_step;
  logic down_step;
  logic count_step;
  logic err_step;
  assign phase_now = {PHASE_A, PHASE_B};
  assign moved = enabled && (phase_now != phase_q);

  // Forward sequence is 00, 10, 11, 01 and back to 00.
  function automatic logic [1:0] next_up(input logic [1:0] p);
    case (p)
      2'h0: next_up = 2'h2;
      2'h2: next_up = 2'h3;
      2'h3: next_up = 2'h1;
      default: next_up = 2'h0;
    endcase
  endfunction : next_up

  assign up_step = moved && (phase_now == next_up(phase_q));
  assign down_step = moved && (phase_q == next_up(phase_now));
  assign err_step = moved && !up_step && !down_step;
  // Double-edge mode counts edges of phase A only.
  assign count_step = (up_step || down_step) && (quad_mode || (phase_now[1] != phase_q[1]));

  // Previous phase is kept to find transitions.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_now;
    end
  end

  // ===================================================================
  // Index qualification
  logic index_gated;
  logic [1:0] up_from;
  logic idx_evt;
  assign index_gated = INDEX && cfg3_q[CFG3_IDX_EN];
  // Up transition is up_from to next_up(up_from); down is its reverse.
  // match table
  always_comb begin
    case (index_match_select)
      2'h0: up_from = 2'h0;
      2'h1: up_from = 2'h2;
      2'h2: up_from = 2'h1;
      default: up_from = 2'h3;
    endcase
  end
  // Both counting modes are edge modes, so the match always applies.
  // index event
  assign idx_evt = index_gated && ((up_step && phase_q == up_from) ||
                   (down_step && phase_now == up_from));

  // ===================================================================
  // Position counter
  logic tc_evt;
  logic do_reload;
  logic dir_chg;
  assign tc_evt = count_step && (up_step ? (cnt_q == max_q) : (cnt_q == 16'h0000));
  assign do_reload = (idx_evt && reload_mode[0]) || (tc_evt && reload_mode[1]);
  assign dir_chg = (up_step || down_step) && (up_step != dir_q);

  // Counter steps, reloads, or takes a preset while disabled.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_q <= CNT_RESET;
    end else if (!enabled) begin
      if (wr_acc && reg_idx == IDX_CNT_LO) begin
        cnt_q[7:0] <= wdata;
      end
      if (wr_acc && reg_idx == IDX_CNT_HI) begin
        cnt_q[15:8] <= wdata;
      end
    end else if (do_reload) begin
      cnt_q <= up_step ? 16'h0000 : max_q;
    end else if (count_step) begin
      cnt_q <= up_step ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
    end
  end

  // Direction of the last valid step.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dir_q <= 1'b1;
    end else if (up_step || down_step) begin
      dir_q <= up_step;
    end
  end

  // ===================================================================
  // Event flags and interrupt
  logic [NUM_EVT-1:0] evt;
  assign evt[EV_ERR] = err_step;
  assign evt[EV_CNT] = count_step || (idx_evt && do_reload);
  assign evt[EV_DIR] = dir_chg;
  assign evt[EV_IDX] = idx_evt;
  assign evt[EV_TC] = tc_evt;

  // Flags clear by writing zero; a new event wins over the clear.
  genvar g;
  generate
    for (g = 0; g < NUM_EVT; g++) begin : g_flag
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          flag_q[g] <= 1'b0;
        end else if (evt[g]) begin
          flag_q[g] <= 1'b1;
        end else if (wr_acc && reg_idx == IDX_FLAGS && !wdata[EVT_LO + g]) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt is the registered OR of enabled flags.
  // interrupt request
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flag_q & cfg3_q[EVT_LO +: NUM_EVT]);
    end
  end

  // ===================================================================
  // Read data, captured in the setup phase
  logic [7:0] rd_byte;
  always_comb begin
    case (reg_idx)
      IDX_CTRL: rd_byte = {3'h0, dir_q, ctrl_q[3:0]};
      IDX_CFG3: rd_byte = cfg3_q;
      IDX_FLAGS: rd_byte = {flag_q, 3'h0};
      IDX_CNT_LO: rd_byte = cnt_q[7:0];
      IDX_CNT_HI: rd_byte = cnt_q[15:8];
      IDX_MAX_LO: rd_byte = max_q[7:0];
      IDX_MAX_HI: rd_byte = max_q[15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  // Unmapped reads return zero.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // ===================================================================
  // Assertions
  a_tc_flag_set: assert property (@(posedge CLK) disable iff (SYS_RST)
    tc_evt |=> flag_q[EV_TC]) else $error("Terminal event did not set its flag.");
  a_index_gated_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    !cfg3_q[CFG3_IDX_EN] |-> !idx_evt) else $error("Index seen while input disabled.");
  a_index_match_up: assert property (@(posedge CLK) disable iff (SYS_RST)
    (idx_evt && up_step) |-> (phase_q == up_from && INDEX))
    else $error("Index event on wrong phase transition.");
  a_count_read_byte: assert property (@(posedge CLK) disable iff (SYS_RST)
    (rd_setup && reg_idx == IDX_CNT_LO) |=> PRDATA[7:0] == $past(cnt_q[7:0]))
    else $error("Count low read mismatch.");
  a_preset_load: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!enabled && wr_acc && reg_idx == IDX_CNT_HI) |=> cnt_q[15:8] == $past(PWDATA[7:0]))
    else $error("Count preset not loaded.");
  a_enabled_no_preset: assert property (@(posedge CLK) disable iff (SYS_RST)
    (enabled && !count_step && !idx_evt) |=> $stable(cnt_q))
    else $error("Count changed without a step while enabled.");
  a_tc_reload_up: assert property (@(posedge CLK) disable iff (SYS_RST)
    (tc_evt && up_step && reload_mode == RLD_TC) |=> cnt_q == 16'h0000)
    else $error("Terminal reload did not clear count.");
  a_wrap_free: assert property (@(posedge CLK) disable iff (SYS_RST)
    (up_step && count_step && reload_mode == RLD_NONE && cnt_q == 16'hFFFF)
    |=> cnt_q == 16'h0000) else $error("Counter did not wrap.");
  a_index_reload_dn: assert property (@(posedge CLK) disable iff (SYS_RST)
    (idx_evt && down_step && reload_mode == RLD_INDEX) |=> cnt_q == $past(max_q))
    else $error("Index reload down did not load maximum.");
  a_irq_raise: assert property (@(posedge CLK) disable iff (SYS_RST)
    (|(flag_q & cfg3_q[EVT_LO +: NUM_EVT])) |=> IRQ)
    else $error("Interrupt missing for enabled flag.");
  a_irq_masked: assert property (@(posedge CLK) disable iff (SYS_RST)
    !(|(flag_q & cfg3_q[EVT_LO +: NUM_EVT])) |=> !IRQ)
    else $error("Interrupt raised with no enabled flag.");
  a_max_write_lo: assert property (@(posedge CLK) disable iff (SYS_RST)
    (wr_acc && reg_idx == IDX_MAX_LO) |=> max_q[7:0] == $past(PWDATA[7:0]))
    else $error("Maximum low byte write not stored.");
  a_index_reload_up: assert property (@(posedge CLK) disable iff (SYS_RST)
    (idx_evt && up_step && reload_mode == RLD_INDEX) |=> cnt_q == 16'h0000)
    else $error("Index reload up did not clear count.");

endmodule : quadrature_decoder_counter

// File: tb_quadrature_decoder_counter.sv
`timescale 1ns/100ps
// ==========
// Bench for the decoder: APB master, encoder model and scenarios.
module tb_quadrature_decoder_counter;
  import qd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, irq;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, a, b, idx;
  logic [31:0] rd;
  int err_count = 0, checked = 0, cyc = 0;
  quadrature_decoder_counter quadrature_decoder_counter_i (.CLK(clk), .SYS_RST(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PHASE_A(a), .PHASE_B(b),
    .INDEX(idx), .IRQ(irq));
  encoder_model encoder_model_i (.CLK(clk), .PHASE_A(a), .PHASE_B(b), .INDEX(idx));
  // Clock of 40 ns and a cycle counter that ends a hung run.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      finish_test();
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen high at an edge.
  task automatic apb(input bit wr, input logic [15:0] ix, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd_cnt(input logic [15:0] exp);
    logic [7:0] lo;
    apb(1'b0, IDX_CNT_LO, 8'h00);
    lo = rd[7:0];
    apb(1'b0, IDX_CNT_HI, 8'h00);
    chk("count", exp, {rd[7:0], lo});
  endtask : rd_cnt
  // Stops the decoder and presets count and maximum.
  task automatic setup(input logic [15:0] cnt, input logic [15:0] mx);
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b1, IDX_CNT_LO, cnt[7:0]);
    apb(1'b1, IDX_CNT_HI, cnt[15:8]);
    apb(1'b1, IDX_MAX_LO, mx[7:0]);
    apb(1'b1, IDX_MAX_HI, mx[15:8]);
  endtask : setup
  task automatic align(input logic [1:0] p);
    while (encoder_model_i.pos != p) encoder_model_i.step(1'b1, 1'b0);
  endtask : align
  // Configuration register 3, count and maximum registers read zero after reset, an unmapped place too.
  task automatic test_reset();
    logic [15:0] ix [6];
    ix = '{IDX_CFG3, IDX_CNT_LO, IDX_CNT_HI, IDX_MAX_LO, IDX_MAX_HI, 16'hA071};
    foreach (ix[i]) begin
      apb(1'b0, ix[i], 8'h00);
      chk("reset value", 16'h0000, rd[15:0]);
      chk("error response", 16'h0000, 16'(pslverr));
    end
  endtask : test_reset
  // Count preset only while stopped, wrap through 0xFFFF both ways.
  task automatic test_preset_wrap();
    setup(16'h1234, 16'h0000);
    rd_cnt(16'h1234);
    apb(1'b1, IDX_CTRL, 8'h03);
    apb(1'b1, IDX_CNT_LO, 8'h55); // software presets only when stopped
    rd_cnt(16'h1234);
    setup(16'hFFFF, 16'h0000);
    apb(1'b1, IDX_CTRL, 8'h03);
    encoder_model_i.step(1'b1, 1'b0);
    rd_cnt(16'h0000);
    encoder_model_i.step(1'b0, 1'b0);
    rd_cnt(16'hFFFF);
  endtask : test_preset_wrap
  // Terminal count reloads, raises its flag and interrupt, then masked.
  task automatic test_tc();
    setup(16'h0003, 16'h0003);
    apb(1'b1, IDX_CTRL, 8'h0B);
    apb(1'b1, IDX_CFG3, 8'h80);
    apb(1'b1, IDX_FLAGS, 8'h00);
    encoder_model_i.step(1'b1, 1'b0);
    rd_cnt(16'h0000);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("tc flag", 16'h0001, 16'(rd[EVT_LO + EV_TC]));
    chk("irq on", 16'h0001, 16'(irq));
    apb(1'b1, IDX_CFG3, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 16'h0000, 16'(irq));
    encoder_model_i.step(1'b0, 1'b0);
    rd_cnt(16'h0003);
  endtask : test_tc
  // Each match code qualifies only its own transition; gating blocks it.
  task automatic test_index();
    int start [4];
    start = '{0, 1, 3, 2};
    setup(16'h0100, 16'h0000);
    apb(1'b1, IDX_CTRL, 8'h03);
    for (int c = 0; c < 5; c++) begin
      for (int t = 0; t < 4; t++) begin
        apb(1'b1, IDX_CFG3, (c == 4) ? 8'h00 : 8'(4 + c));
        align(2'(t));
        apb(1'b1, IDX_FLAGS, 8'h00);
        encoder_model_i.step(1'b1, 1'b1);
        apb(1'b0, IDX_FLAGS, 8'h00);
        chk("index flag", 16'((c < 4) && (t == start[c % 4])), 16'(rd[EVT_LO + EV_IDX]));
      end
    end
  endtask : test_index
  // Index reload to zero up and to maximum down; mode 11 on either event.
  task automatic test_reload();
    setup(16'h0002, 16'h0005);
    align(2'h0);
    apb(1'b1, IDX_CFG3, 8'h04);
    apb(1'b1, IDX_CTRL, 8'h07);
    encoder_model_i.step(1'b1, 1'b1);
    rd_cnt(16'h0000);
    encoder_model_i.step(1'b0, 1'b1);
    rd_cnt(16'h0005);
    setup(16'h0005, 16'h0005);
    apb(1'b1, IDX_CTRL, 8'h0F);
    encoder_model_i.step(1'b1, 1'b0);
    rd_cnt(16'h0000);
    encoder_model_i.step(1'b1, 1'b0);
    align(2'h0);
    encoder_model_i.step(1'b1, 1'b1);
    rd_cnt(16'h0000);
  endtask : test_reload
  // Double-edge mode counts phase A edges only, still matches the index,
  // and the direction-change enable alone drives the interrupt.
  task automatic test_double();
    setup(16'h0010, 16'h0000);
    align(2'h0);
    apb(1'b1, IDX_CFG3, 8'h24);
    apb(1'b1, IDX_CTRL, 8'h01);
    apb(1'b1, IDX_FLAGS, 8'h00);
    encoder_model_i.step(1'b1, 1'b1);
    encoder_model_i.step(1'b1, 1'b0);
    rd_cnt(16'h0011);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("double index flag", 16'h0001, 16'(rd[EVT_LO + EV_IDX]));
    chk("irq no dir", 16'h0000, 16'(irq));
    encoder_model_i.step(1'b0, 1'b0);
    encoder_model_i.step(1'b0, 1'b0);
    rd_cnt(16'h0010);
    chk("irq dir", 16'h0001, 16'(irq));
  endtask : test_double
  // Reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_preset_wrap();
    test_tc();
    test_index();
    test_reload();
    test_double();
    finish_test();
  end
endmodule : tb_quadrature_decoder_counter
